// [src/mwcd_device.sv]
// Command decoder end: slave receiver, margining and watchdog.
// Assumes the interface resolves SDA and the master keeps its own rules.
`timescale 1ns/100ps
module mwcd_device #(
	parameter int MS_CYCLES = mwcd_pkg::WD_MS_CYC
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Link
	mwcd_if.device          bus,
	// Address straps, high when open
	input  wire logic       osc_mode_and_id_bit1_pin,
	input  wire logic       addr_strap_pin,
	// Drive of the link data line
	output logic            sda_oe,
	// Margin settings
	output logic [3:0]      linear_regulator_margin,
	output logic [3:0]      switcher_margin,
	// Watchdog
	output logic            wd_enabled,
	output logic            wd_windowed,
	output logic [1:0]      wd_period_sel,
	output logic            wd_timeout,
	output logic            cmd_discard
);
	localparam int MSW = $clog2(MS_CYCLES + 1);

	logic [3:0]           pins_s;
	logic                 scl_s;
	logic                 sda_s;
	logic                 scl_d_r;
	logic                 sda_d_r;
	mwcd_pkg::mwcd_dstate_t state_r;
	logic [7:0]           sh_r;
	logic [2:0]           bit_r;
	logic                 full_r;
	logic                 ack_r;
	logic [1:0]           credit_r;
	logic                 wd_arm_r;
	logic [3:0]           lin_r;
	logic [3:0]           sw_r;
	logic                 wd_en_r;
	logic                 wd_win_r;
	logic [1:0]           wd_sel_r;
	logic [MSW-1:0]       ms_cnt_r;
	logic [10:0]          wd_ms_r;
	logic                 tmo_r;
	logic                 disc_r;

	// ==========================================
	// Pin sampling.
	mwcd_sync2 #(.W(4)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({bus.scl, bus.sda, osc_mode_and_id_bit1_pin, addr_strap_pin}),
		.q     (pins_s)
	);
	assign scl_s = pins_s[3];
	assign sda_s = pins_s[2];

	// ==========================================
	// Bus events and address match.
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start    = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop     = scl_s & scl_d_r & ~sda_d_r & sda_s;
	wire [6:0] own_addr = {mwcd_pkg::ADDR_HI, pins_s[1:0]};
	wire addr_ok  = (sh_r[7:1] == own_addr) && (sh_r[0] == mwcd_pkg::RW_WRITE);
	wire byte_end = scl_fall & full_r;
	wire data_stb = byte_end & (state_r == mwcd_pkg::D_DATA);

	// ==========================================
	// Field split and decode of a received byte.
	wire [2:0] op  = sh_r[mwcd_pkg::OP_MSB:mwcd_pkg::OP_LSB];
	wire [4:0] val = sh_r[mwcd_pkg::VAL_MSB:0];
	wire is_m  = (op == mwcd_pkg::OP_MARGIN);
	wire is_wd = (op == mwcd_pkg::OP_WD);
	wire val_z = (val == mwcd_pkg::VAL_ZERO);
	wire m_ok  = is_m & (credit_r != 2'h0) & (val[3:0] != mwcd_pkg::M_UNDEF);
	wire wd_ok = is_wd & wd_arm_r & ~val[4] & (val[mwcd_pkg::WD_EN_BIT] | val_z);
	wire arm_m = is_m & val_z & ~m_ok;
	wire arm_w = is_wd & val_z & ~wd_ok;
	wire wd_off  = wd_ok & val_z;
	wire wd_prog = wd_ok & ~val_z;

	// ==========================================
	// Watchdog period, window and timeout causes.
	logic [10:0] period_ms;
	always_comb begin
		case (wd_sel_r)
			2'h0: period_ms = mwcd_pkg::WD_MS_P0;
			2'h1: period_ms = mwcd_pkg::WD_MS_P1;
			2'h2: period_ms = mwcd_pkg::WD_MS_P2;
			default: period_ms = mwcd_pkg::WD_MS_P3;
		endcase
	end
	wire ms_tick = (ms_cnt_r == MSW'(MS_CYCLES - 1));
	wire expire  = wd_en_r & ms_tick & (wd_ms_r == period_ms - 11'h001);
	wire early   = wd_en_r & wd_win_r & (wd_ms_r < (period_ms >> 1));
	wire reload  = data_stb & wd_prog & ~early;
	wire block   = data_stb & wd_prog & early;

	// ==========================================
	// Edge history for event detection.
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_d_r <= 1'h1;
			sda_d_r <= 1'h1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// ==========================================
	// Slave receiver: shift on rise, acknowledge a matching write address and each data byte.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= mwcd_pkg::D_IDLE;
			bit_r   <= 3'h0;
			full_r  <= 1'h0;
			ack_r   <= 1'h0;
			sh_r    <= 8'h00;
		end else if (start) begin
			state_r <= mwcd_pkg::D_ADDR;
			bit_r   <= 3'h0;
			full_r  <= 1'h0;
			ack_r   <= 1'h0;
		end else if (stop) begin
			state_r <= mwcd_pkg::D_IDLE;
			ack_r   <= 1'h0;
			full_r  <= 1'h0;
		end else begin
			case (state_r)
				mwcd_pkg::D_ADDR, mwcd_pkg::D_DATA: begin
					if (scl_rise) begin
						sh_r   <= {sh_r[6:0], sda_s};
						bit_r  <= bit_r + 3'h1;
						full_r <= (bit_r == 3'h7);
					end else if (byte_end) begin
						full_r <= 1'h0;
						if (state_r == mwcd_pkg::D_DATA || addr_ok) begin
							ack_r   <= 1'h1;
							state_r <= mwcd_pkg::D_ACK;
						end else begin
							state_r <= mwcd_pkg::D_IDLE;
						end
					end
				end
				mwcd_pkg::D_ACK: begin
					if (scl_fall) begin
						ack_r   <= 1'h0;
						state_r <= mwcd_pkg::D_DATA;
					end
				end
				default: begin
					state_r <= mwcd_pkg::D_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Arming: margin grants two bytes, watchdog one; others disarm.
	always_ff @(posedge clk) begin
		if (reset || stop || start) begin
			credit_r <= 2'h0;
			wd_arm_r <= 1'h0;
		end else if (data_stb) begin
			wd_arm_r <= arm_w;
			if (arm_m) begin
				credit_r <= mwcd_pkg::M_CREDITS;
			end else if (m_ok) begin
				credit_r <= credit_r - 2'h1;
			end else begin
				credit_r <= 2'h0;
			end
		end
	end

	// ==========================================
	// Margin settings per regulator.
	always_ff @(posedge clk) begin
		if (reset) begin
			lin_r <= mwcd_pkg::M_NOMINAL;
			sw_r  <= mwcd_pkg::M_NOMINAL;
		end else if (data_stb && m_ok) begin
			if (val[mwcd_pkg::M_SEL_BIT]) begin
				sw_r <= val[3:0];
			end else begin
				lin_r <= val[3:0];
			end
		end
	end

	// ==========================================
	// Watchdog mode and timers.
	always_ff @(posedge clk) begin
		if (reset) begin
			wd_en_r  <= 1'h0;
			wd_win_r <= 1'h0;
			wd_sel_r <= 2'h0;
			ms_cnt_r <= '0;
			wd_ms_r  <= 11'h000;
		end else if (data_stb && wd_off) begin
			wd_en_r  <= 1'h0;
			ms_cnt_r <= '0;
			wd_ms_r  <= 11'h000;
		end else if (reload) begin
			wd_en_r  <= 1'h1;
			wd_win_r <= val[mwcd_pkg::WD_WIN_BIT];
			wd_sel_r <= val[1:0];
			ms_cnt_r <= '0;
			wd_ms_r  <= 11'h000;
		end else if (wd_en_r) begin
			ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + MSW'(1);
			if (expire) begin
				wd_ms_r <= 11'h000;
			end else if (ms_tick) begin
				wd_ms_r <= wd_ms_r + 11'h001;
			end
		end
	end

	// ==========================================
	// Event pulses.
	always_ff @(posedge clk) begin
		if (reset) begin
			tmo_r  <= 1'h0;
			disc_r <= 1'h0;
		end else begin
			tmo_r  <= expire | block;
			disc_r <= data_stb & ~m_ok & ~wd_ok & ~arm_m & ~arm_w;
		end
	end

	// ==========================================
	// Outputs from flops.
	assign sda_oe                  = ack_r;
	assign bus.d_sda_oe            = ack_r;
	assign linear_regulator_margin = lin_r;
	assign switcher_margin         = sw_r;
	assign wd_enabled              = wd_en_r;
	assign wd_windowed             = wd_win_r;
	assign wd_period_sel           = wd_sel_r;
	assign wd_timeout              = tmo_r;
	assign cmd_discard             = disc_r;
endmodule

// [src/mwcd_pkg.sv]
// Constants and types shared by both ends of the command link.
// Assumes a 10 MHz system clock on both ends.
package mwcd_pkg;
	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_PERIOD_NS = 1600;
	localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int MS_NS         = 1000000;
	localparam int WD_MS_CYC     = MS_NS / CLK_PERIOD_NS;
	localparam logic [10:0] WD_MS_P0 = 11'h500;
	localparam logic [10:0] WD_MS_P1 = 11'h140;
	localparam logic [10:0] WD_MS_P2 = 11'h050;
	localparam logic [10:0] WD_MS_P3 = 11'h014;
	// ==========================================
	// Command byte layout
	localparam int OP_MSB      = 7;
	localparam int OP_LSB      = 5;
	localparam int VAL_MSB     = 4;
	localparam int M_SEL_BIT   = 4;
	localparam int WD_EN_BIT   = 3;
	localparam int WD_WIN_BIT  = 2;
	localparam logic [2:0] OP_MARGIN = 3'h1;
	localparam logic [2:0] OP_WD     = 3'h3;
	localparam logic [4:0] VAL_ZERO  = 5'h00;
	localparam logic [3:0] M_UNDEF   = 4'hF;
	localparam logic [3:0] M_NOMINAL = 4'h0;
	localparam logic [1:0] M_CREDITS = 2'h2;
	// ==========================================
	// Addressing
	localparam logic [4:0] ADDR_HI  = 5'h0A;
	localparam logic       RW_WRITE = 1'h0;
	// ==========================================
	// State machines
	typedef enum logic [3:0] {
		D_IDLE = 4'h1,
		D_ADDR = 4'h2,
		D_ACK  = 4'h4,
		D_DATA = 4'h8
	} mwcd_dstate_t;
	typedef enum logic [5:0] {
		H_IDLE  = 6'h01,
		H_START = 6'h02,
		H_BIT   = 6'h04,
		H_ACK   = 6'h08,
		H_WAIT  = 6'h10,
		H_STOP  = 6'h20
	} mwcd_hstate_t;
endpackage

// [src/mwcd_if.sv]
// Two-wire link between the command master and the decoder.
// Assumes SDA is open drain with a pull-up; SCL is driven by the master.
`timescale 1ns/100ps
interface mwcd_if;
	logic scl;
	logic m_sda_oe;
	logic d_sda_oe;
	logic sda;
	// ==========================================
	// Wired-AND of the open-drain data line.
	assign sda = ~(m_sda_oe | d_sda_oe);
	modport host (output scl, output m_sda_oe, input sda);
	modport device (input scl, output d_sda_oe, input sda);
endinterface

// [src/mwcd_sync2.sv]
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes the inputs are levels; the first stage feeds only the second.
`timescale 1ns/100ps
module mwcd_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// ==========================================
	// Both stages reset to the idle-high level of the lines, so no false edge follows reset.
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= '1;
			q      <= '1;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// [src/mwcd_host.sv]
// Command master end: sends address and command bytes, then STOP.
// Assumes the user keeps each byte stable while cmd_valid is high.
`timescale 1ns/100ps
module mwcd_host (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Link
	mwcd_if.host            bus,
	// Command port
	input  wire logic [6:0] target_addr,
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_byte,
	input  wire logic       cmd_last,
	output logic            cmd_ready,
	// Status
	output logic            busy,
	output logic            nack
);
	localparam int QW = $clog2(mwcd_pkg::SCL_QTR_CYC + 1);

	logic                   sda_s;
	logic [QW-1:0]          q_cnt_r;
	logic [1:0]             ph_r;
	mwcd_pkg::mwcd_hstate_t st_r;
	logic [7:0]             sh_r;
	logic [7:0]             data_r;
	logic [2:0]             bit_r;
	logic                   last_r;
	logic                   is_addr_r;
	logic                   scl_r;
	logic                   oe_r;
	logic                   rdy_r;
	logic                   busy_r;
	logic                   nack_r;

	// ==========================================
	// Returned data line sampling.
	mwcd_sync2 #(.W(1)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     (bus.sda),
		.q     (sda_s)
	);

	// ==========================================
	// Quarter-bit enable and accept strobe.
	wire qtick  = (q_cnt_r == QW'(mwcd_pkg::SCL_QTR_CYC - 1));
	wire accept = cmd_valid & rdy_r;

	always_ff @(posedge clk) begin
		if (reset || !busy_r) begin
			q_cnt_r <= '0;
		end else begin
			q_cnt_r <= qtick ? '0 : q_cnt_r + QW'(1);
		end
	end

	// ==========================================
	// Bit sequencer; SCL is the divided clock.
	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= mwcd_pkg::H_IDLE;
			ph_r <= 2'h0;
			sh_r <= 8'h00;
			data_r <= 8'h00;
			bit_r <= 3'h0;
			last_r <= 1'h0;
			is_addr_r <= 1'h0;
			scl_r <= 1'h1;
			oe_r <= 1'h0;
			rdy_r <= 1'h1;
			busy_r <= 1'h0;
			nack_r <= 1'h0;
		end else if (accept) begin
			rdy_r <= 1'h0;
			busy_r <= 1'h1;
			ph_r <= 2'h0;
			last_r <= cmd_last;
			if (st_r == mwcd_pkg::H_WAIT) begin
				sh_r <= cmd_byte;
				st_r <= mwcd_pkg::H_BIT;
			end else begin
				data_r <= cmd_byte;
				sh_r <= {target_addr, mwcd_pkg::RW_WRITE};
				is_addr_r <= 1'h1;
				nack_r <= 1'h0;
				st_r <= mwcd_pkg::H_START;
			end
		end else if (qtick) begin
			ph_r <= ph_r + 2'h1;
			case (st_r)
				mwcd_pkg::H_START: begin
					if (ph_r == 2'h0) oe_r <= 1'h1;
					if (ph_r == 2'h2) scl_r <= 1'h0;
					if (ph_r == 2'h3) st_r <= mwcd_pkg::H_BIT;
				end
				mwcd_pkg::H_BIT: begin
					if (ph_r == 2'h0) oe_r <= ~sh_r[7];
					if (ph_r == 2'h1) scl_r <= 1'h1;
					if (ph_r == 2'h3) begin
						scl_r <= 1'h0;
						sh_r <= {sh_r[6:0], 1'h0};
						bit_r <= bit_r + 3'h1;
						if (bit_r == 3'h7) st_r <= mwcd_pkg::H_ACK;
					end
				end
				mwcd_pkg::H_ACK: begin
					if (ph_r == 2'h0) oe_r <= 1'h0;
					if (ph_r == 2'h1) scl_r <= 1'h1;
					if (ph_r == 2'h3) begin
						scl_r <= 1'h0;
						is_addr_r <= 1'h0;
						nack_r <= sda_s;
						if (sda_s || (last_r && !is_addr_r)) begin
							st_r <= mwcd_pkg::H_STOP;
						end else if (is_addr_r) begin
							sh_r <= data_r;
							st_r <= mwcd_pkg::H_BIT;
						end else begin
							rdy_r <= 1'h1;
							busy_r <= 1'h0;
							st_r <= mwcd_pkg::H_WAIT;
						end
					end
				end
				mwcd_pkg::H_STOP: begin
					if (ph_r == 2'h0) oe_r <= 1'h1;
					if (ph_r == 2'h1) scl_r <= 1'h1;
					if (ph_r == 2'h2) oe_r <= 1'h0;
					if (ph_r == 2'h3) begin
						rdy_r <= 1'h1;
						busy_r <= 1'h0;
						st_r <= mwcd_pkg::H_IDLE;
					end
				end
				default: begin
					ph_r <= 2'h0;
				end
			endcase
		end
	end

	// ==========================================
	// Outputs from flops.
	assign bus.scl      = scl_r;
	assign bus.m_sda_oe = oe_r;
	assign cmd_ready    = rdy_r;
	assign busy         = busy_r;
	assign nack         = nack_r;
endmodule

// [testbench/mwcd_props.sv]
// Checker for the two-wire link between the command master and the decoder.
// Assumes it is instantiated beside the interface and sees its signals plainly.
`timescale 1ns/100ps
module mwcd_props (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Link signals
	input  wire logic scl,
	input  wire logic m_sda_oe,
	input  wire logic d_sda_oe,
	input  wire logic sda
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// ==========================================
	// Framing helpers
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	wire        start_w    = scl & scl_q & sda_q & ~sda;
	wire        stop_w     = scl & scl_q & ~sda_q & sda;
	wire        scl_rise_w = scl & ~scl_q;
	// Bit position since START; it wraps on the rising clock of the ack bit so each byte counts 0 to 8.
	assign bit_nxt = start_w ? 4'h0 : (!scl_rise_w ? bit_r : ((bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1));
	// Previous line levels and the bit position register.
	always_ff @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		bit_r <= reset ? 4'h0 : bit_nxt;
	end
	// ==========================================
	// Steps of a transfer
	sequence s_ack_begin;
		!d_sda_oe ##1 d_sda_oe;
	endsequence
	sequence s_stop;
		stop_w;
	endsequence
	a_ack_after_eight: assert property (s_ack_begin |-> bit_r == 4'h8)
		else $error("ack started away from the ninth bit");
	a_ack_scl_low: assert property (s_ack_begin |-> !scl)
		else $error("ack started while the clock was high");
	a_ack_holds: assert property (s_ack_begin |-> d_sda_oe [*8])
		else $error("ack dropped too early");
	a_ack_spans_pulse: assert property (s_ack_begin |-> d_sda_oe throughout (##[1:16] scl_rise_w))
		else $error("ack did not cover a clock pulse");
	a_ack_ends: assert property (s_ack_begin |-> ##[9:24] !d_sda_oe)
		else $error("ack was not released in time");
	a_release_scl_low: assert property ($fell(d_sda_oe) |-> !scl)
		else $error("ack released while the clock was high");
	a_quiet_scl_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
		else $error("decoder moved data while the clock was high");
	a_idle_after_stop: assert property (s_stop |-> !d_sda_oe [*4])
		else $error("decoder drove data after stop");
	c_ack_seen: cover property (s_ack_begin);
endmodule

// [testbench/margin_watchdog_cmd_decoder_tb.sv]
// Self-checking bench: host and decoder joined by the link, compared with a model.
// Assumes the decoder counts ten clocks per watchdog millisecond.
`timescale 1ns/100ps
module margin_watchdog_cmd_decoder_tb;
	localparam int MS = 10;
	// ==========================================
	// Design connections
	logic       clk         = 1'h0;
	logic       reset       = 1'h1;
	logic       s1          = 1'h1;
	logic       s0          = 1'h1;
	logic [6:0] target_addr = 7'h00;
	logic       cmd_valid   = 1'h0;
	logic [7:0] cmd_byte    = 8'h00;
	logic       cmd_last    = 1'h0;
	logic       cmd_ready, busy, nack, sda_oe;
	logic       wd_enabled, wd_windowed, wd_timeout, cmd_discard;
	logic [3:0] lin, sw;
	logic [1:0] per;
	int         errors = 0;
	int         check_count = 0;
	int         m_lin, m_sw, m_en, m_win, m_per, cred, wd_arm, early;
	int         disc_cnt, exp_disc, to_cnt, n, t0;
	mwcd_if lnk();
	mwcd_host mwcd_host_inst (.clk(clk), .reset(reset), .bus(lnk), .target_addr(target_addr),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_last(cmd_last),
		.cmd_ready(cmd_ready), .busy(busy), .nack(nack));
	mwcd_device #(.MS_CYCLES(MS)) mwcd_device_inst (.clk(clk), .reset(reset), .bus(lnk),
		.osc_mode_and_id_bit1_pin(s1), .addr_strap_pin(s0), .sda_oe(sda_oe),
		.linear_regulator_margin(lin), .switcher_margin(sw), .wd_enabled(wd_enabled),
		.wd_windowed(wd_windowed), .wd_period_sel(per), .wd_timeout(wd_timeout),
		.cmd_discard(cmd_discard));
	mwcd_props mwcd_props_inst (.clk(clk), .reset(reset), .scl(lnk.scl),
		.m_sda_oe(lnk.m_sda_oe), .d_sda_oe(lnk.d_sda_oe), .sda(lnk.sda));
	// Clock of 100 ns.
	initial begin
		forever #50 clk = ~clk;
	end
	// Counts discard and timeout pulses where they are settled.
	always @(negedge clk) begin
		if (cmd_discard === 1'h1) disc_cnt++;
		if (wd_timeout === 1'h1) to_cnt++;
	end
	// ==========================================
	// Helpers
	task automatic close_out();
		if (errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [6:0] dev_a();
		return {mwcd_pkg::ADDR_HI, s1, s0};
	endfunction
	// Model of one received data byte; arming state lives only within a transfer.
	task automatic model_byte(input logic [7:0] b);
		if (wd_arm != 0) begin
			wd_arm = 0;
			if (b == 8'h60) m_en = 0;
			else if (b[7:3] == 5'h0D && !(m_en == 1 && m_win == 1 && early == 1)) begin
				m_en = 1;
				m_win = b[2];
				m_per = b[1:0];
			end else if (b == 8'h20) cred = 2;
			else if (b[7:3] != 5'h0D) exp_disc++;
		end else if (cred != 0 && b[7:5] == 3'h1 && b[3:0] != 4'hF) begin
			cred--;
			if (b[4]) m_sw = b[3:0];
			else m_lin = b[3:0];
		end else if (b == 8'h20) cred = 2;
		else if (b == 8'h60) begin
			cred = 0;
			wd_arm = 1;
		end else begin
			cred = 0;
			exp_disc++;
		end
	endtask
	task automatic check_all();
		chk("linear", 16'(m_lin), {12'h000, lin});
		chk("switcher", 16'(m_sw), {12'h000, sw});
		chk("wd enabled", 16'(m_en), {15'h0000, wd_enabled});
		chk("discards", 16'(exp_disc), 16'(disc_cnt));
		if (m_en == 1) begin
			chk("wd windowed", 16'(m_win), {15'h0000, wd_windowed});
			chk("wd period", 16'(m_per), {14'h0000, per});
		end
	endtask
	// Sends one transfer; ok says whether the decoder should take it.
	task automatic xfer(input logic [6:0] a, input logic [7:0] b[$], input int ok);
		cred = 0;
		wd_arm = 0;
		for (int i = 0; i < b.size(); i++) begin
			@(negedge clk);
			target_addr = a;
			cmd_valid = 1'h1;
			cmd_byte = b[i];
			cmd_last = (i == b.size() - 1);
			while (cmd_ready !== 1'h1) @(negedge clk);
			@(posedge clk);
			if (ok != 0) model_byte(b[i]);
		end
		@(negedge clk);
		cmd_valid = 1'h0;
		while (busy !== 1'h0 || cmd_ready !== 1'h1) @(negedge clk);
		repeat (4) @(negedge clk);
		chk("ack drive", 16'h0000, {15'h0000, sda_oe});
		chk("nack", (ok != 0) ? 16'h0000 : 16'h0001, {15'h0000, nack});
		check_all();
	endtask
	task automatic wait_to();
		n = 0;
		@(negedge clk);
		while (wd_timeout !== 1'h1 && n < 30000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hE6E8CB3B));
		repeat (8) @(posedge clk);
		@(negedge clk);
		reset = 1'h0;
		check_all();
		// Every defined margin code, both regulators in random order, every strap setting.
		for (int i = 0; i < 15; i++) begin
			s1 = i[1];
			s0 = i[0];
			t0 = $urandom_range(0, 1);
			xfer(dev_a(), '{8'h20, {3'h1, t0[0], 4'(i)},
				{3'h1, ~t0[0], 4'($urandom_range(0, 14))}}, 1);
		end
		// Bytes that must be thrown away, and a transfer to another address.
		xfer(dev_a(), '{8'h25}, 1);
		xfer(dev_a(), '{8'h20, 8'h2F}, 1);
		xfer(dev_a(), '{8'h60, 8'h25}, 1);
		xfer(dev_a(), '{8'h20}, 1);
		xfer(dev_a(), '{8'h27}, 1);
		xfer(dev_a() ^ 7'h01, '{8'h21}, 0);
		// Watchdog start and exact period.
		xfer(dev_a(), '{8'h60, 8'h6B}, 1);
		wait_to();
		wait_to();
		chk("wd interval", 16'(20 * MS - 1), 16'(n));
		// Disable, then restart over each unwindowed code and a windowed one.
		xfer(dev_a(), '{8'h60, 8'h60}, 1);
		t0 = to_cnt;
		repeat (500) @(negedge clk);
		chk("timeouts off", 16'(t0), 16'(to_cnt));
		for (int c = 8'h68; c <= 8'h6C; c++) xfer(dev_a(), '{8'h60, 8'(c)}, 1);
		// Service before the window opens is refused with a timeout.
		t0 = to_cnt;
		early = 1;
		xfer(dev_a(), '{8'h60, 8'h6E}, 1);
		early = 0;
		chk("early timeout", 16'(t0 + 1), 16'(to_cnt));
		repeat (6600) @(negedge clk);
		xfer(dev_a(), '{8'h60, 8'h6D}, 1);
		xfer(dev_a(), '{8'h60, 8'h60}, 1);
		xfer(dev_a(), '{8'h60, 8'h6F}, 1);
		close_out();
	end
	// Cuts a hang short well past the expected run length.
	initial begin
		#5000000;
		errors++;
		close_out();
	end
endmodule
